/* rtl/bccw_consts.vh */
`ifndef BCCW_CONSTS_VH
`define BCCW_CONSTS_VH

// register byte addresses (16-bit registers, low byte at even address)
`define BCCW_ADDR_TIME 7'h2E
`define BCCW_ADDR_DATE 7'h30
`define BCCW_ADDR_YEAR 7'h32
`define BCCW_ADDR_WTIME 7'h34
`define BCCW_ADDR_WDATE 7'h36
`define BCCW_ADDR_GCMD 7'h4A

// reset values
`define BCCW_RST_TIME 16'h0000
`define BCCW_RST_DATE 16'h0000
`define BCCW_RST_YEAR 16'h0000
`define BCCW_RST_WTIME 16'h0000
`define BCCW_RST_WDATE 16'h0000

// field positions
`define BCCW_HOUR_MSB 13
`define BCCW_HOUR_LSB 8
`define BCCW_MIN_MSB 6
`define BCCW_MIN_LSB 0
`define BCCW_MONTH_MSB 12
`define BCCW_WMONTH_MSB 13
`define BCCW_MONTH_LSB 8
`define BCCW_DAY_MSB 5
`define BCCW_DAY_LSB 0
`define BCCW_YEAR_MSB 7
`define BCCW_YEAR_LSB 0
`define BCCW_WAKE_EN_BIT 15
`define BCCW_GCMD_STANDBY_BIT 2
`define BCCW_GCMD_WAKE_BIT 8

// bcd limits of the minute, hour, month and year pairs; the day maximum comes from days_max
`define BCCW_MIN_MAX 8'h59
`define BCCW_HOUR_MAX 8'h23
`define BCCW_MONTH_MAX 8'h12
`define BCCW_YEAR_MAX 8'h99
`define BCCW_ZERO_MIN 8'h00
`define BCCW_ONE_MIN 8'h01

// timing
`define BCCW_CLK_HZ 64'd100000000
`define BCCW_MINUTE_S 64'd60
`define BCCW_WAKE_TIME_NS 64'd200000
`define BCCW_NS_PER_S 64'd1000000000
`define BCCW_MINUTE_CYCLES (`BCCW_MINUTE_S * `BCCW_CLK_HZ)
// 0.2 ms at 100 MHz, sized to the 32-bit timer so nothing is cut silently
`define BCCW_WAKE_CYCLES 32'd20000

`endif

/* rtl/bccw_bcd_pair.v */
`timescale 1ns/1ns
module bccw_bcd_pair (
    input wire clk_i,
    input wire arst_n_i,
    input wire inc_i,
    input wire load_i,
    input wire [7:0] load_val_i,
    input wire [7:0] min_i,
    input wire [7:0] max_i,
    output reg [7:0] val_o,
    output wire wrap_o
);
    reg [7:0] val_d;

    // out-of-range values written by software still roll over
    assign wrap_o = inc_i & (val_o >= max_i);

    always @* begin
        val_d = val_o;
        if (load_i) begin
            val_d = load_val_i;
        end else if (inc_i) begin
            if (val_o >= max_i) begin
                val_d = min_i;
            end else if (val_o[3:0] >= 4'h9) begin
                val_d = {val_o[7:4] + 4'h1, 4'h0};
            end else begin
                val_d = {val_o[7:4], val_o[3:0] + 4'h1};
            end
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            val_o <= 8'h00;
        end else begin
            val_o <= val_d;
        end
    end
endmodule // bccw_bcd_pair

/* rtl/bccw_wake_timer.v */
`timescale 1ns/1ns
module bccw_wake_timer #(
    parameter [31:0] CYCLES = 32'd20000
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire start_i,
    output reg done_o
);
    reg [31:0] cnt_q;
    reg run_q;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q <= CYCLES - 32'd1;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == 32'h0) begin
                    run_q <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 32'd1;
                end
            end
        end
    end
endmodule // bccw_wake_timer

/* rtl/bccw_top.v */
`timescale 1ns/1ns
`include "bccw_consts.vh"
module bccw_top #(
    parameter [63:0] MINUTE_CYCLES = `BCCW_MINUTE_CYCLES,
    parameter [31:0] WAKE_CYCLES = `BCCW_WAKE_CYCLES
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [6:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire event_capture_i,
    output reg [15:0] stamp_time_o,
    output reg [15:0] stamp_date_o,
    output reg [15:0] stamp_year_o,
    output reg stamp_valid_o,
    output wire standby_o,
    output wire busy_o,
    output reg wake_event_o
);
    ////////////////////////////////////////////////////////////////////////////
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_STBY = 3'b010;
    localparam [2:0] ST_WAKE = 3'b100;

    localparam IDX_MIN = 0;
    localparam IDX_HOUR = 1;
    localparam IDX_DAY = 2;
    localparam IDX_MON = 3;
    localparam IDX_YEAR = 4;

    // bit 0 of the address is ignored; the word is taken whole
    function sel;
        input [6:0] addr;
        input [6:0] target;
        begin
            sel = (addr[6:1] == target[6:1]);
        end
    endfunction

    // last day of a month, bcd; year 00 counts as leap
    function [7:0] days_max;
        input [7:0] month;
        input [7:0] year;
        reg leap;
        begin
            leap = year[4] ? ((year[3:0] == 4'h2) || (year[3:0] == 4'h6))
                           : ((year[3:0] == 4'h0) || (year[3:0] == 4'h4) ||
                              (year[3:0] == 4'h8));
            case (month)
                8'h02: days_max = leap ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: days_max = 8'h30;
                default: days_max = 8'h31;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [63:0] presc_q;
    reg minute_tick_q;
    reg [15:0] wtime_q;
    reg [15:0] wdate_q;
    reg match_q;
    wire wake_done;
    wire wr_ok;
    wire wr_time;
    wire wr_date;
    wire wr_year;
    wire wr_wtime;
    wire wr_wdate;
    wire wr_gcmd;
    wire cmd_standby;
    wire cmd_wake;
    wire alarm_hit;
    wire match;
    wire [4:0] inc;
    wire [4:0] load;
    wire [4:0] wrap;
    wire [39:0] load_val;
    wire [39:0] min_val;
    wire [39:0] max_val;
    wire [39:0] cal;
    wire [15:0] time_rd;
    wire [15:0] date_rd;
    wire [15:0] year_rd;

    assign standby_o = state_q[1];
    assign busy_o = state_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // register port decode; requests are dropped while waking
    assign wr_ok = reg_wr_i & ~state_q[2];
    assign wr_time = wr_ok & sel(reg_addr_i, `BCCW_ADDR_TIME);
    assign wr_date = wr_ok & sel(reg_addr_i, `BCCW_ADDR_DATE);
    assign wr_year = wr_ok & sel(reg_addr_i, `BCCW_ADDR_YEAR);
    assign wr_wtime = wr_ok & sel(reg_addr_i, `BCCW_ADDR_WTIME);
    assign wr_wdate = wr_ok & sel(reg_addr_i, `BCCW_ADDR_WDATE);
    assign wr_gcmd = wr_ok & sel(reg_addr_i, `BCCW_ADDR_GCMD);
    assign cmd_standby = wr_gcmd & reg_wdata_i[`BCCW_GCMD_STANDBY_BIT];
    assign cmd_wake = wr_gcmd & reg_wdata_i[`BCCW_GCMD_WAKE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // minute prescaler; a time write restarts the minute
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc_q <= 64'h0;
            minute_tick_q <= 1'b0;
        end else begin
            minute_tick_q <= 1'b0;
            if (wr_time) begin
                presc_q <= 64'h0;
            end else if (presc_q >= MINUTE_CYCLES - 64'd1) begin
                presc_q <= 64'h0;
                minute_tick_q <= 1'b1;
            end else begin
                presc_q <= presc_q + 64'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calendar chain: minute, hour, day, month, year
    assign inc = {wrap[3:0], minute_tick_q};
    assign load = {wr_year, wr_date, wr_date, wr_time, wr_time};
    assign load_val[IDX_MIN*8 +: 8] = {1'b0, reg_wdata_i[`BCCW_MIN_MSB:`BCCW_MIN_LSB]};
    assign load_val[IDX_HOUR*8 +: 8] =
        {2'b00, reg_wdata_i[`BCCW_HOUR_MSB:`BCCW_HOUR_LSB]};
    assign load_val[IDX_DAY*8 +: 8] = {2'b00, reg_wdata_i[`BCCW_DAY_MSB:`BCCW_DAY_LSB]};
    assign load_val[IDX_MON*8 +: 8] =
        {3'b000, reg_wdata_i[`BCCW_MONTH_MSB:`BCCW_MONTH_LSB]};
    assign load_val[IDX_YEAR*8 +: 8] = reg_wdata_i[`BCCW_YEAR_MSB:`BCCW_YEAR_LSB];
    assign min_val = {`BCCW_ZERO_MIN, `BCCW_ONE_MIN, `BCCW_ONE_MIN, `BCCW_ZERO_MIN,
                      `BCCW_ZERO_MIN};
    // 24-hour roll at 23, day limit from month and leap year
    assign max_val = {`BCCW_YEAR_MAX, `BCCW_MONTH_MAX,
                      days_max(cal[IDX_MON*8 +: 8], cal[IDX_YEAR*8 +: 8]),
                      `BCCW_HOUR_MAX, `BCCW_MIN_MAX};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_pair
            bccw_bcd_pair u_pair (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .inc_i(inc[gi]),
                .load_i(load[gi]),
                .load_val_i(load_val[gi*8 +: 8]),
                .min_i(min_val[gi*8 +: 8]),
                .max_i(max_val[gi*8 +: 8]),
                .val_o(cal[gi*8 +: 8]),
                .wrap_o(wrap[gi])
            );
        end
    endgenerate

    // register images, unused bits read zero
    assign time_rd = {2'b00, cal[IDX_HOUR*8 +: 6], 1'b0, cal[IDX_MIN*8 +: 7]};
    assign date_rd = {3'b000, cal[IDX_MON*8 +: 5], 2'b00, cal[IDX_DAY*8 +: 6]};
    assign year_rd = {8'h00, cal[IDX_YEAR*8 +: 8]};

    ////////////////////////////////////////////////////////////////////////////
    // wake registers
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wtime_q <= `BCCW_RST_WTIME;
            wdate_q <= `BCCW_RST_WDATE;
        end else begin
            if (wr_wtime) begin
                wtime_q <= {reg_wdata_i[`BCCW_WAKE_EN_BIT], 1'b0,
                            reg_wdata_i[`BCCW_HOUR_MSB:`BCCW_HOUR_LSB], 1'b0,
                            reg_wdata_i[`BCCW_MIN_MSB:`BCCW_MIN_LSB]};
            end
            if (wr_wdate) begin
                wdate_q <= {2'b00, reg_wdata_i[`BCCW_WMONTH_MSB:`BCCW_MONTH_LSB], 2'b00,
                            reg_wdata_i[`BCCW_DAY_MSB:`BCCW_DAY_LSB]};
            end
        end
    end

    // exact compare; only the first cycle of a match fires, so entering
    // standby inside the matching minute does not wake at once
    assign match = (wtime_q[`BCCW_HOUR_MSB:`BCCW_HOUR_LSB] == time_rd[13:8]) &&
                   (wtime_q[`BCCW_MIN_MSB:`BCCW_MIN_LSB] == time_rd[6:0]) &&
                   (wdate_q[`BCCW_WMONTH_MSB:`BCCW_MONTH_LSB] == {1'b0, date_rd[12:8]}) &&
                   (wdate_q[`BCCW_DAY_MSB:`BCCW_DAY_LSB] == date_rd[5:0]);
    assign alarm_hit = wtime_q[`BCCW_WAKE_EN_BIT] & match & ~match_q;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (cmd_wake) begin
                    state_d = ST_WAKE;
                end else if (cmd_standby) begin
                    state_d = ST_STBY;
                end
            end
            ST_STBY: begin
                if (cmd_wake || alarm_hit) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_done) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_RUN;
            wake_event_o <= 1'b0;
        end else begin
            state_q <= state_d;
            wake_event_o <= state_q[1] & state_d[2];
        end
    end

    bccw_wake_timer #(
        .CYCLES(WAKE_CYCLES)
    ) u_wake_timer (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .start_i(state_d[2] & ~state_q[2]),
        .done_o(wake_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port, one cycle latency; unmapped and command reads give zero
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i & ~state_q[2];
            if (reg_rd_i && !state_q[2]) begin
                if (sel(reg_addr_i, `BCCW_ADDR_TIME)) begin
                    reg_rdata_o <= time_rd;
                end else if (sel(reg_addr_i, `BCCW_ADDR_DATE)) begin
                    reg_rdata_o <= date_rd;
                end else if (sel(reg_addr_i, `BCCW_ADDR_YEAR)) begin
                    reg_rdata_o <= year_rd;
                end else if (sel(reg_addr_i, `BCCW_ADDR_WTIME)) begin
                    reg_rdata_o <= wtime_q;
                end else if (sel(reg_addr_i, `BCCW_ADDR_WDATE)) begin
                    reg_rdata_o <= wdate_q;
                end else begin
                    reg_rdata_o <= 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event header stamp
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stamp_time_o <= 16'h0000;
            stamp_date_o <= 16'h0000;
            stamp_year_o <= 16'h0000;
            stamp_valid_o <= 1'b0;
        end else begin
            stamp_valid_o <= event_capture_i;
            if (event_capture_i) begin
                stamp_time_o <= time_rd;
                stamp_date_o <= date_rd;
                stamp_year_o <= year_rd;
            end
        end
    end
endmodule // bccw_top

/* tb/bccw_top_assertions.sv */
`timescale 1ns/1ns
module bccw_top_assertions #(
    parameter [31:0] WAKE_CYCLES = 32'd5
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire [6:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire reg_rvalid_o,
    input wire event_capture_i,
    input wire stamp_valid_o,
    input wire standby_o,
    input wire busy_o,
    input wire wake_event_o
);
    ////////////////////////////////////////////////////////////////////////////////
    reg [31:0] busy_cnt_q;
    wire cmd_wr;
    // a counter keeps the busy span check free of long repetitions
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    // bit 0 of the address is ignored by the word port
    assign cmd_wr = reg_wr_i && !busy_o && (reg_addr_i[6:1] == 6'h25);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (reg_rd_i && !busy_o |=> reg_rvalid_o)
        else $error("accepted read gave no answer");
    read_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i) && !$past(busy_o))
        else $error("answer without accepted read");
    stamp_pulse_a: assert property (event_capture_i && !busy_o |=> stamp_valid_o)
        else $error("capture gave no stamp");
    standby_enter_a: assert property (cmd_wr && reg_wdata_i[2] && !reg_wdata_i[8]
        && !standby_o |=> standby_o)
        else $error("standby command ignored");
    // a wake command in run mode starts busy too, but only leaving standby pulses
    wake_command_a: assert property (cmd_wr && reg_wdata_i[8]
        |=> busy_o && !standby_o && (wake_event_o == $past(standby_o)))
        else $error("wake command ignored");
    busy_long_a: assert property ($fell(busy_o) |-> busy_cnt_q >= WAKE_CYCLES)
        else $error("busy span too short");
    busy_short_a: assert property (busy_o |-> busy_cnt_q <= WAKE_CYCLES + 32'd1)
        else $error("busy span too long");
    leave_standby_a: assert property ($fell(standby_o) |-> wake_event_o && busy_o)
        else $error("standby left without wake");
    wake_pulse_a: assert property (wake_event_o |=> !wake_event_o)
        else $error("wake event longer than a cycle");
endmodule // bccw_top_assertions

bind bccw_top bccw_top_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) bccw_top_assertions_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
    .event_capture_i(event_capture_i), .stamp_valid_o(stamp_valid_o),
    .standby_o(standby_o), .busy_o(busy_o), .wake_event_o(wake_event_o));

/* tb/bccw_top_tb.sv */
`timescale 1ns/1ns
`include "bccw_consts.vh"
module bccw_top_tb;
    localparam [63:0] MIN_CYC = 64'd20;
    localparam [31:0] WAKE_CYC = 32'd5;
    localparam [6:0] TA = `BCCW_ADDR_TIME;
    localparam [6:0] WT = `BCCW_ADDR_WTIME;
    localparam [6:0] WD = `BCCW_ADDR_WDATE;
    localparam [6:0] GC = `BCCW_ADDR_GCMD;
    reg clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg [6:0] reg_addr_i = 7'h00;
    reg [15:0] reg_wdata_i = 16'h0000;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg event_capture_i = 1'b0;
    wire [15:0] reg_rdata_o, stamp_time_o, stamp_date_o, stamp_year_o;
    wire reg_rvalid_o, stamp_valid_o, standby_o, busy_o, wake_event_o;
    integer num_errors = 0;
    integer checks = 0;
    integer i;
    reg rv;
    reg [38:0] rows [0:6];
`define CHK(got, exp) begin checks = checks + 1; if ((got) !== (exp)) begin \
    num_errors = num_errors + 1; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

    bccw_top #(.MINUTE_CYCLES(MIN_CYC), .WAKE_CYCLES(WAKE_CYC)) bccw_top_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .event_capture_i(event_capture_i), .stamp_time_o(stamp_time_o),
        .stamp_date_o(stamp_date_o), .stamp_year_o(stamp_year_o),
        .stamp_valid_o(stamp_valid_o), .standby_o(standby_o), .busy_o(busy_o),
        .wake_event_o(wake_event_o));

    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask

    task wr(input [6:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask

    task rd_chk(input [6:0] a, input [15:0] exp);
        begin
            @(posedge clk_i);
            reg_addr_i <= a;
            reg_rd_i <= 1'b1;
            @(posedge clk_i);
            reg_rd_i <= 1'b0;
            #1;
            rv = reg_rvalid_o;
            // only a read known to be dropped skips the data check
            if (rv !== 1'b0) `CHK(reg_rdata_o, exp)
        end
    endtask

    // sets the clock just before a year-end style carry, then reads back
    task cal(input [15:0] y, input [15:0] d, input [15:0] ed, input [15:0] ey);
        begin
            wr(`BCCW_ADDR_YEAR, y);
            wr(`BCCW_ADDR_DATE, d);
            wr(TA, 16'h2359);
            repeat (MIN_CYC + 64'd3) @(posedge clk_i);
            rd_chk(TA, 16'h0000);
            rd_chk(`BCCW_ADDR_DATE, ed);
            rd_chk(`BCCW_ADDR_YEAR, ey);
            $display("test calendar done");
        end
    endtask

    task alarm(input [15:0] wt, input [15:0] wd, input exp);
        reg seen;
        integer j;
        begin
            wr(TA, 16'h0959);
            wr(WD, wd);
            wr(WT, wt);
            wr(GC, 16'h0004);
            #1 `CHK(standby_o, 1'b1)
            seen = 1'b0;
            for (j = 0; j < 40; j = j + 1) begin
                @(posedge clk_i);
                #1 if (wake_event_o === 1'b1) seen = 1'b1;
            end
            `CHK(seen, exp)
            if (!exp) begin
                wr(GC, 16'h0100);
                #1 `CHK({busy_o, wake_event_o, standby_o}, 3'b110)
                rd_chk(TA, 16'h1000);
                `CHK(rv, 1'b0)
            end
            for (j = 0; j < WAKE_CYC + 4 && busy_o === 1'b1; j = j + 1) begin
                @(posedge clk_i);
                #1;
            end
            `CHK({busy_o, standby_o}, 2'b00)
            $display("test alarm done");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = {TA, 16'hE231, 16'h2231};
        rows[1] = {`BCCW_ADDR_DATE, 16'hF234, 16'h1234};
        rows[2] = {`BCCW_ADDR_YEAR, 16'hAB99, 16'h0099};
        rows[3] = {WT, 16'hFFFF, 16'hBF7F};
        rows[4] = {WD, 16'hFFFF, 16'h3F3F};
        rows[5] = {GC, 16'h0000, 16'h0000};
        rows[6] = {7'h40, 16'h5555, 16'h0000};
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (i = 0; i < 5; i = i + 1) rd_chk(TA + 7'(2 * i), 16'h0000);
        $display("test reset done");
        for (i = 0; i < 7; i = i + 1) begin
            wr(rows[i][38:32], rows[i][31:16]);
            rd_chk(rows[i][38:32], rows[i][15:0]);
            `CHK(rv, 1'b1)
        end
        $display("test rows done");
        // reset again in mid-run, registers now hold nonzero values
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (i = 1; i < 5; i = i + 1) rd_chk(TA + 7'(2 * i), 16'h0000);
        $display("test second reset done");
        cal(16'h0099, 16'h1231, 16'h0101, 16'h0000);
        cal(16'h0024, 16'h0228, 16'h0229, 16'h0024);
        cal(16'h0023, 16'h0228, 16'h0301, 16'h0023);
        cal(16'h0023, 16'h0430, 16'h0501, 16'h0023);
        wr(TA, 16'h1015);
        @(posedge clk_i);
        event_capture_i <= 1'b1;
        @(posedge clk_i);
        event_capture_i <= 1'b0;
        #1 `CHK({stamp_valid_o, stamp_time_o}, 17'h11015)
        `CHK({stamp_date_o, stamp_year_o}, 32'h05010023)
        rd_chk(TA, 16'h1015);
        $display("test stamp done");
        // wake at 10:00, bcd hour digits, enable in the top bit
        alarm(16'h1000, 16'h0501, 1'b0);
        alarm(16'h9000, 16'h0502, 1'b0);
        alarm(16'h9000, 16'h0501, 1'b1);
        complete_run;
    end

    initial begin
        #100000;
        num_errors = num_errors + 1;
        $display("watchdog expired");
        complete_run;
    end
endmodule // bccw_top_tb
